// ### logic/ufs_map.vh
// Register map, field positions and reset values of the serial core
`ifndef UFS_MAP_VH
`define UFS_MAP_VH
`define UFS_A_DATA   12'h000
`define UFS_A_RSR    12'h004
`define UFS_A_FLAG   12'h018
`define UFS_A_ILPR   12'h020
`define UFS_A_DIV    12'h024
`define UFS_A_LCR    12'h02C
`define UFS_A_CTL    12'h030
`define UFS_A_LVL    12'h034
`define UFS_A_MASK   12'h038
`define UFS_A_RIS    12'h03C
`define UFS_A_MIS    12'h040
`define UFS_A_ICR    12'h044
// Line control fields
`define UFS_LC_BRK   0
`define UFS_LC_PEN   1
`define UFS_LC_EPS   2
`define UFS_LC_STP2  3
`define UFS_LC_FEN   4
`define UFS_LC_WLO   5
`define UFS_LC_WHI   6
`define UFS_LC_SPS   7
// Control fields
`define UFS_CT_EN    0
`define UFS_CT_SIR   1
`define UFS_CT_LP    2
`define UFS_CT_LBE   7
`define UFS_CT_TXE   8
`define UFS_CT_RXE   9
// Event bits
`define UFS_EV_RX    4
`define UFS_EV_TX    5
`define UFS_EV_RT    6
`define UFS_EV_FE    7
`define UFS_EV_PE    8
`define UFS_EV_BE    9
`define UFS_EV_OE    10
// Reset values
`define UFS_CTL_RST  10'h300
`define UFS_LVL_RST  6'h12
`define UFS_DIV_RST  16'h0001
`define UFS_ILP_RST  8'h01
// Timing in oversample ticks; the low-power pulse is counted in low-power ticks
`define UFS_T_START  4'h7
`define UFS_T_BIT    4'hF
`define UFS_T_PULSE  4'h3
`define UFS_LP_PULSE 2'h3
`endif

// ### logic/ufs_core.v
// Serial core with FIFOs, infrared codec, event logic and APB slave
`timescale 1ns/1ps
`include "ufs_map.vh"
module ufs_core #(
	parameter DEPTH   = 16,
	parameter AW      = 4,
	parameter RT_BITS = 9
) (
	// Clock, reset, enable
	input  wire        pclk,
	input  wire        presetn,
	input  wire        pclk_en,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Serial pins and request
	input  wire        serial_in,
	output reg         serial_out,
	output reg         irq
);
	localparam RX_IDLE = 3'd0;
	localparam RX_START = 3'd1;
	localparam RX_DATA = 3'd2;
	localparam RX_PAR = 3'd3;
	localparam RX_STOP = 3'd4;

	// Trigger count for a level select code
	function [AW:0] ufs_lvl;
		input [2:0] sel;
		begin
			case (sel)
				3'd0: ufs_lvl = DEPTH[AW:0] >> 3;
				3'd1: ufs_lvl = DEPTH[AW:0] >> 2;
				3'd2: ufs_lvl = DEPTH[AW:0] >> 1;
				3'd3: ufs_lvl = (DEPTH[AW:0] >> 1) + (DEPTH[AW:0] >> 2);
				default: ufs_lvl = DEPTH[AW:0] - (DEPTH[AW:0] >> 3);
			endcase
		end
	endfunction

	// Registers
	reg [7:0]       line_control_reg;
	reg [9:0]       control_reg;
	reg [5:0]       fifo_level_select;
	reg [10:0]      irq_mask_reg;
	reg [10:0]      raw_irq_status;
	reg [15:0]      div_r;
	reg [7:0]       ilpr_r;
	reg [3:0]       rx_status_reg;
	// FIFO storage and pointers
	reg [7:0]       tx_mem [0:DEPTH-1];
	reg [11:0]      rx_mem [0:DEPTH-1];
	reg [AW-1:0]    tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	reg [AW:0]      tx_cnt_r, rx_cnt_r, tx_prev_r, rx_prev_r;
	// Timing
	reg [15:0]      bcnt_r;
	reg [7:0]       lpcnt_r;
	// Transmitter
	reg [11:0]      tx_sh_r;
	reg [3:0]       tx_left_r, tx_sub_r;
	reg             tx_act_r;
	reg [1:0]       lp_pulse_r;
	// Receiver
	reg [2:0]       sy_r;
	reg             rx_f_r, rx_prev_line_r;
	reg [3:0]       ir_hold_r;
	reg [2:0]       rx_st_r;
	reg [3:0]       rx_sub_r;
	reg [2:0]       rx_bit_r;
	reg [7:0]       rx_dat_r;
	reg             rx_pe_r, oe_pend_r;
	reg [RT_BITS:0] rt_cnt_r;

	// Decoded controls
	wire       fifo_enable_bit  = line_control_reg[`UFS_LC_FEN];
	wire [1:0] wlen = line_control_reg[`UFS_LC_WHI:`UFS_LC_WLO];
	wire       sir  = control_reg[`UFS_CT_SIR];
	wire       loopback_enable_bit  = control_reg[`UFS_CT_LBE];
	wire       uen  = control_reg[`UFS_CT_EN];
	wire [AW:0] depth = fifo_enable_bit ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};
	wire [AW:0] tx_lv = ufs_lvl(fifo_level_select[2:0]);
	wire [AW:0] rx_lv = fifo_enable_bit ? ufs_lvl(fifo_level_select[5:3]) : {{AW{1'b0}}, 1'b1};
	wire tx_full = tx_cnt_r >= depth;
	wire rx_full = rx_cnt_r >= depth;
	wire tx_empty = tx_cnt_r == 0;
	wire rx_empty = rx_cnt_r == 0;
	wire busy = !tx_empty || tx_act_r;

	// Ticks
	wire tick = bcnt_r == 0;
	wire lp_tick = lpcnt_r == 0;

	// Bus phases
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite;
	wire rd = acc && !pwrite;
	wire wr_dat = wr && paddr == `UFS_A_DATA;
	wire rd_dat = rd && paddr == `UFS_A_DATA;
	wire [10:0] clr = (wr && paddr == `UFS_A_ICR) ? pwdata[10:0] : 11'h000;

	// FIFO handshakes
	wire tx_push = wr_dat && !tx_full;
	wire tx_start = tick && !tx_act_r && !tx_empty && uen && control_reg[`UFS_CT_TXE];
	wire rx_pop = rd_dat && !rx_empty;
	wire tx_bit_end = tick && tx_act_r && tx_sub_r == `UFS_T_BIT;

	// Frame assembly: start, data, parity, stops
	reg [11:0] fr;
	reg [3:0]  fr_len;
	reg        par;
	integer    i;
	always @* begin
		fr = 12'hFFF;
		par = line_control_reg[`UFS_LC_SPS] ? !line_control_reg[`UFS_LC_EPS] :
			(^(tx_mem[tx_rp_r] & (8'hFF >> (2'd3 - wlen))) ^ !line_control_reg[`UFS_LC_EPS]);
		fr[0] = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			if (i < wlen + 5)
				fr[i+1] = tx_mem[tx_rp_r][i];
		end
		if (line_control_reg[`UFS_LC_PEN])
			fr[wlen+6] = par;
		fr_len = {2'b00, wlen} + 4'd7 + {3'b000, line_control_reg[`UFS_LC_PEN]}
			+ {3'b000, line_control_reg[`UFS_LC_STP2]};
	end

	// Receive line source: pin with codec, or own stream in loopback
	wire tx_line = tx_act_r ? tx_sh_r[0] : 1'b1;
	wire ir_bit = !(rx_f_r == 1'b0 || ir_hold_r != 0);
	wire rx_raw = sir ? ir_bit : rx_f_r;
	wire rx_in = loopback_enable_bit ? tx_line : ((sir && tx_act_r) ? 1'b1 : rx_raw);

	// Receive word with status
	wire fe_now = !rx_in;
	wire be_now = fe_now && rx_dat_r == 8'h00 && !rx_pe_r;
	wire rx_done = tick && rx_st_r == RX_STOP && rx_sub_r == `UFS_T_BIT;
	wire rx_push = rx_done && !rx_full;
	wire rx_ovr = rx_done && rx_full;
	wire [11:0] rx_word = {oe_pend_r, be_now, rx_pe_r, fe_now, rx_dat_r};

	// Event conditions
	wire rx_hit = rx_cnt_r >= rx_lv;
	wire tx_set = fifo_enable_bit ? (tx_prev_r > tx_lv && tx_cnt_r <= tx_lv) : (tx_prev_r != 0 && tx_empty);
	wire tx_off = fifo_enable_bit ? (tx_cnt_r > tx_lv) : !tx_empty;
	wire rt_hit = rt_cnt_r[RT_BITS];

	// APB answer, flags and read mux
	reg [31:0] rmux;
	reg        rbad;
	always @* begin
		rbad = 1'b0;
		rmux = 32'h0000_0000;
		case (paddr)
			`UFS_A_DATA: rmux = {20'h0_0000, rx_mem[rx_rp_r]};
			`UFS_A_RSR:  rmux = {28'h000_0000, rx_status_reg};
			`UFS_A_FLAG: rmux = {24'h00_0000, tx_empty, rx_full, tx_full, rx_empty, busy, 3'b000};
			`UFS_A_ILPR: rmux = {24'h00_0000, ilpr_r};
			`UFS_A_DIV:  rmux = {16'h0000, div_r};
			`UFS_A_LCR:  rmux = {24'h00_0000, line_control_reg};
			`UFS_A_CTL:  rmux = {22'h00_0000, control_reg};
			`UFS_A_LVL:  rmux = {26'h000_0000, fifo_level_select};
			`UFS_A_MASK: rmux = {21'h00_0000, irq_mask_reg};
			`UFS_A_RIS:  rmux = {21'h00_0000, raw_irq_status};
			`UFS_A_MIS:  rmux = {21'h00_0000, raw_irq_status & irq_mask_reg};
			`UFS_A_ICR:  rmux = 32'h0000_0000;
			default:     rbad = 1'b1;
		endcase
	end

	// Bus slave: one wait state, data registered
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (pclk_en) begin
			if (psel && penable && !pready) begin
				pready <= 1'b1;
				pslverr <= rbad;
				prdata <= pwrite ? 32'h0000_0000 : rmux;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// Software registers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_control_reg <= 8'h00;
			control_reg <= `UFS_CTL_RST;
			fifo_level_select <= `UFS_LVL_RST;
			irq_mask_reg <= 11'h000;
			div_r <= `UFS_DIV_RST;
			ilpr_r <= `UFS_ILP_RST;
		end else if (pclk_en && wr) begin
			case (paddr)
				`UFS_A_LCR:  line_control_reg <= pwdata[7:0];
				`UFS_A_CTL:  control_reg <= pwdata[9:0];
				`UFS_A_LVL:  fifo_level_select <= pwdata[5:0];
				`UFS_A_MASK: irq_mask_reg <= pwdata[10:0];
				`UFS_A_DIV:  div_r <= pwdata[15:0];
				`UFS_A_ILPR: ilpr_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Oversample and low-power tick dividers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bcnt_r <= 16'h0000;
			lpcnt_r <= 8'h00;
		end else if (pclk_en) begin
			bcnt_r <= (tick || div_r <= 16'h0001) ? div_r - 16'h0001 : bcnt_r - 16'h0001;
			lpcnt_r <= (lp_tick || ilpr_r <= 8'h01 || tx_start || tx_bit_end) ? ilpr_r - 8'h01 : lpcnt_r - 8'h01;
		end
	end

	// Transmit FIFO
	always @(posedge pclk) begin
		if (pclk_en && tx_push)
			tx_mem[tx_wp_r] <= pwdata[7:0];
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_wp_r <= {AW{1'b0}};
			tx_rp_r <= {AW{1'b0}};
			tx_cnt_r <= {(AW+1){1'b0}};
			tx_prev_r <= {{AW{1'b0}}, 1'b1};
		end else if (pclk_en) begin
			if (!fifo_enable_bit && tx_push)
				tx_wp_r <= tx_rp_r;
			else if (tx_push)
				tx_wp_r <= tx_wp_r + 1'b1;
			if (tx_start)
				tx_rp_r <= fifo_enable_bit ? tx_rp_r + 1'b1 : tx_rp_r;
			tx_cnt_r <= tx_cnt_r + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_start};
			tx_prev_r <= tx_cnt_r;
		end
	end

	// Transmit shifter and infrared encoder
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_act_r <= 1'b0;
			tx_sh_r <= 12'hFFF;
			tx_left_r <= 4'h0;
			tx_sub_r <= 4'h0;
			lp_pulse_r <= 2'b00;
			serial_out <= 1'b1;
		end else if (pclk_en) begin
			if (tx_start) begin
				tx_act_r <= 1'b1;
				tx_sh_r <= fr;
				tx_left_r <= fr_len - 4'd1;
				tx_sub_r <= 4'h0;
				lp_pulse_r <= `UFS_LP_PULSE;
			end else if (tick && tx_act_r) begin
				tx_sub_r <= tx_sub_r + 4'h1;
				if (tx_bit_end) begin
					tx_sh_r <= {1'b1, tx_sh_r[11:1]};
					tx_left_r <= tx_left_r - 4'h1;
					tx_act_r <= tx_left_r != 0;
					lp_pulse_r <= tx_sh_r[1] ? 2'b00 : `UFS_LP_PULSE;
				end else if (lp_tick && lp_pulse_r != 2'b00) begin
					lp_pulse_r <= lp_pulse_r - 2'b01;
				end
			end else if (lp_tick && lp_pulse_r != 0) begin
				lp_pulse_r <= lp_pulse_r - 2'b01;
			end
			if (line_control_reg[`UFS_LC_BRK])
				serial_out <= sir ? 1'b0 : 1'b0;
			else if (!sir)
				serial_out <= tx_line;
			else if (control_reg[`UFS_CT_LP])
				serial_out <= tx_act_r && !tx_sh_r[0] && lp_pulse_r != 0;
			else
				serial_out <= tx_act_r && !tx_sh_r[0] && tx_sub_r < `UFS_T_PULSE;
		end
	end

	// Pin synchroniser and infrared pulse stretch
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy_r <= 3'b111;
			rx_f_r <= 1'b1;
			ir_hold_r <= 4'h0;
			rx_prev_line_r <= 1'b1;
		end else if (pclk_en) begin
			sy_r <= {sy_r[1:0], serial_in};
			if (sy_r[1] == sy_r[2])
				rx_f_r <= sy_r[2];
			if (!rx_f_r)
				ir_hold_r <= `UFS_T_BIT;
			else if (tick && ir_hold_r != 0)
				ir_hold_r <= ir_hold_r - 4'h1;
			rx_prev_line_r <= rx_in;
		end
	end

	// Receiver state machine
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st_r <= RX_IDLE;
			rx_sub_r <= 4'h0;
			rx_bit_r <= 3'd0;
			rx_dat_r <= 8'h00;
			rx_pe_r <= 1'b0;
		end else if (pclk_en) begin
			case (rx_st_r)
				RX_IDLE: begin
					if (rx_prev_line_r && !rx_in && uen && control_reg[`UFS_CT_RXE]) begin
						rx_st_r <= RX_START;
						rx_sub_r <= 4'h0;
					end
				end
				RX_START: if (tick) begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `UFS_T_START) begin
						rx_st_r <= rx_in ? RX_IDLE : RX_DATA;
						rx_sub_r <= 4'h0;
						rx_bit_r <= 3'd0;
						rx_dat_r <= 8'h00;
						rx_pe_r <= 1'b0;
					end
				end
				RX_DATA: if (tick) begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `UFS_T_BIT) begin
						rx_dat_r[rx_bit_r] <= rx_in;
						rx_bit_r <= rx_bit_r + 3'd1;
						if (rx_bit_r == {1'b0, wlen} + 3'd4)
							rx_st_r <= line_control_reg[`UFS_LC_PEN] ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: if (tick) begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `UFS_T_BIT) begin
						rx_st_r <= RX_STOP;
						rx_pe_r <= rx_in != (line_control_reg[`UFS_LC_SPS] ? !line_control_reg[`UFS_LC_EPS] :
							(^rx_dat_r ^ !line_control_reg[`UFS_LC_EPS]));
					end
				end
				RX_STOP: if (tick) begin
					rx_sub_r <= rx_sub_r + 4'h1;
					if (rx_sub_r == `UFS_T_BIT)
						rx_st_r <= RX_IDLE;
				end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// Receive FIFO with status bits
	always @(posedge pclk) begin
		if (pclk_en && rx_push)
			rx_mem[rx_wp_r] <= rx_word;
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_wp_r <= {AW{1'b0}};
			rx_rp_r <= {AW{1'b0}};
			rx_cnt_r <= {(AW+1){1'b0}};
			rx_prev_r <= {(AW+1){1'b0}};
			oe_pend_r <= 1'b0;
			rx_status_reg <= 4'h0;
		end else if (pclk_en) begin
			if (!fifo_enable_bit && rx_push)
				rx_wp_r <= rx_rp_r;
			else if (rx_push)
				rx_wp_r <= rx_wp_r + 1'b1;
			if (rx_pop && fifo_enable_bit)
				rx_rp_r <= rx_rp_r + 1'b1;
			rx_cnt_r <= rx_cnt_r + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
			rx_prev_r <= rx_cnt_r;
			if (rx_ovr)
				oe_pend_r <= 1'b1;
			else if (rx_push)
				oe_pend_r <= 1'b0;
			// Overrun sticks until a write here; set beats clear
			if (wr && paddr == `UFS_A_RSR)
				rx_status_reg <= {rx_ovr, 3'b000};
			else if (rx_pop)
				rx_status_reg <= {rx_mem[rx_rp_r][11] | rx_ovr | rx_status_reg[3], rx_mem[rx_rp_r][10:8]};
			else if (rx_ovr)
				rx_status_reg[3] <= 1'b1;
		end
	end

	// Receive idle timer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rt_cnt_r <= {(RT_BITS+1){1'b0}};
		else if (pclk_en) begin
			if (rx_empty || rx_st_r != RX_IDLE || rx_pop || rt_hit)
				rt_cnt_r <= {(RT_BITS+1){1'b0}};
			else if (tick)
				rt_cnt_r <= rt_cnt_r + 1'b1;
		end
	end

	// Raw events, mask and request; set beats clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			raw_irq_status <= 11'h000;
			irq <= 1'b0;
		end else if (pclk_en) begin
			raw_irq_status[3:0] <= 4'h0;
			raw_irq_status[`UFS_EV_RX] <= (rx_hit && rx_prev_r < rx_lv) ||
				(raw_irq_status[`UFS_EV_RX] && rx_hit && !clr[`UFS_EV_RX]);
			raw_irq_status[`UFS_EV_TX] <= tx_set ||
				(raw_irq_status[`UFS_EV_TX] && !tx_off && !clr[`UFS_EV_TX]);
			raw_irq_status[`UFS_EV_RT] <= rt_hit || (raw_irq_status[`UFS_EV_RT] && !clr[`UFS_EV_RT]);
			raw_irq_status[`UFS_EV_FE] <= (rx_push && fe_now) || (raw_irq_status[`UFS_EV_FE] && !clr[`UFS_EV_FE]);
			raw_irq_status[`UFS_EV_PE] <= (rx_push && rx_pe_r) || (raw_irq_status[`UFS_EV_PE] && !clr[`UFS_EV_PE]);
			raw_irq_status[`UFS_EV_BE] <= (rx_push && be_now) || (raw_irq_status[`UFS_EV_BE] && !clr[`UFS_EV_BE]);
			raw_irq_status[`UFS_EV_OE] <= rx_ovr || (raw_irq_status[`UFS_EV_OE] && !clr[`UFS_EV_OE]);
			irq <= |(raw_irq_status & irq_mask_reg);
		end
	end
endmodule // ufs_core

// ### dv/ufs_monitor.sv
// Checker on the serial core ports
`timescale 1ns/1ps
`include "ufs_map.vh"
module ufs_monitor (
	// Clock, reset, enable
	input wire        pclk,
	input wire        presetn,
	input wire        pclk_en,
	// APB slave
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// Serial pins and request
	input wire        serial_in,
	input wire        serial_out,
	input wire        irq
);
	reg  [9:0]  ctl_r;
	reg  [15:0] div_r;
	reg  [7:0]  ilp_r;
	reg  [10:0] msk_r;
	reg  [15:0] run_r;
	reg         last_r;
	reg         arm_r;
	wire        wr_ok = psel && penable && pwrite && pready;
	wire        ctl_w = wr_ok && paddr == `UFS_A_CTL;
	wire        rd_fl = pready && !pwrite && paddr == `UFS_A_FLAG;
	wire        ir    = ctl_r[`UFS_CT_SIR];
	// Shadow of setup writes and length of the present pin level
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r  <= `UFS_CTL_RST;
			div_r  <= `UFS_DIV_RST;
			ilp_r  <= `UFS_ILP_RST;
			msk_r  <= 11'h000;
			run_r  <= 16'h0000;
			last_r <= 1'b1;
			arm_r  <= 1'b0;
		end else begin
			if (ctl_w) ctl_r <= pwdata[9:0];
			if (wr_ok && paddr == `UFS_A_DIV) div_r <= pwdata[15:0];
			if (wr_ok && paddr == `UFS_A_ILPR) ilp_r <= pwdata[7:0];
			if (wr_ok && paddr == `UFS_A_MASK) msk_r <= pwdata[10:0];
			// Runs counted in enabled cycles only
			if (pclk_en) begin
				run_r  <= (serial_out == last_r) ? run_r + 16'h0001 : 16'h0001;
				last_r <= serial_out;
			end
			arm_r  <= !ctl_w && (arm_r || serial_out == !ir);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_answer;
		psel && $rose(penable) |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer) else $error("pready late or long");
	property p_err;
		pslverr && !pwrite |-> pready && prdata == 32'h0000_0000;
	endproperty
	a_err: assert property (p_err) else $error("refused read with data");
	property p_width;
		pready && !pwrite && paddr == `UFS_A_DATA |-> prdata[31:12] == 20'h0_0000;
	endproperty
	a_width: assert property (p_width) else $error("data word too wide");
	property p_flags;
		rd_fl |-> !(prdata[7] && prdata[5]) && !(prdata[4] && prdata[6]);
	endproperty
	a_flags: assert property (p_flags) else $error("empty and full together");
	property p_busy;
		rd_fl |-> prdata[7] || prdata[3];
	endproperty
	a_busy: assert property (p_busy) else $error("queued data but not busy");
	property p_idle;
		rd_fl && !prdata[3] && !ir |-> serial_out;
	endproperty
	a_idle: assert property (p_idle) else $error("line low while not busy");
	property p_mask;
		msk_r == 11'h000 && $past(msk_r) == 11'h000 |-> !irq;
	endproperty
	a_mask: assert property (p_mask) else $error("request with all masked");
	property p_bit;
		arm_r && !ir && $rose(serial_out) |-> run_r % (16 * div_r) == 0;
	endproperty
	a_bit: assert property (p_bit) else $error("low run not whole bits");
	property p_pulse;
		arm_r && ir && $fell(serial_out) |-> run_r == (ctl_r[`UFS_CT_LP] ? 3 * ilp_r : 3 * div_r);
	endproperty
	a_pulse: assert property (p_pulse) else $error("infrared pulse width");
endmodule // ufs_monitor

bind ufs_core ufs_monitor u_mon (
	.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out), .irq(irq)
);

// ### dv/ufs_peer.sv
// Remote serial node on the far side of the pins
`timescale 1ns/1ps
module ufs_peer #(
	parameter BITC = 16
) (
	// Clock
	input  wire  pclk,
	// Serial lines
	input  wire  line_in,
	output logic line_out
);
	logic [7:0] rx_byte;
	logic [7:0] sh;
	int         rx_count;
	initial begin
		line_out = 1'b1;
		rx_byte  = 8'h00;
		rx_count = 0;
	end
	// Frame receiver, each bit taken in its middle
	always begin
		@(negedge line_in);
		repeat (BITC / 2) @(posedge pclk);
		if (!line_in) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BITC) @(posedge pclk);
				sh[i] = line_in;
			end
			repeat (BITC) @(posedge pclk);
			rx_byte = sh;
			rx_count++;
		end
	end
	// One frame, only on command, with the stop bit at the given level
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		@(posedge pclk);
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (BITC) @(posedge pclk);
		end
		line_out <= 1'b1;
	endtask
	// Low level of n clocks, then release to the pulled-up idle
	task automatic glitch(input int n);
		@(posedge pclk);
		line_out <= 1'b0;
		repeat (n) @(posedge pclk);
		line_out <= 1'b1;
	endtask
endmodule // ufs_peer

// ### dv/tb_top.sv
// Self-checking bench for the serial core
`timescale 1ns/1ps
`include "ufs_map.vh"
module tb_top;
	logic        pclk         = 1'b0;
	logic        presetn      = 1'b0;
	logic        pclk_en      = 1'b1;
	logic        psel         = 1'b0;
	logic        penable      = 1'b0;
	logic        pwrite       = 1'b0;
	logic [11:0] paddr        = 12'h000;
	logic [31:0] pwdata       = 32'h0000_0000;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         serial_in;
	wire         serial_out;
	wire         irq;
	logic        so_q         = 1'b1;
	logic [31:0] rv;
	logic        re;
	int          n_rise       = 0;
	int          n_mismatch   = 0;
	int          total_checks = 0;
	int          n0;
	always #5 pclk = ~pclk;
	ufs_core u_dut (
		.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out), .irq(irq)
	);
	ufs_peer u_peer (.pclk(pclk), .line_in(serial_out), .line_out(serial_in));
	// Counts infrared pulses on the transmit pin
	always @(posedge pclk) begin
		so_q <= serial_out;
		if (serial_out && !so_q) n_rise <= n_rise + 1;
	end
	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [11:0] d);
		int k;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {20'h0_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rv = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [11:0] d);
		apb(1'b1, a, d);
	endtask
	// Read and compare masked low bits
	task automatic rck(input logic [11:0] a, input logic [11:0] m, input logic [11:0] e);
		apb(1'b0, a, 12'h000);
		chk({20'h0_0000, rv[11:0] & m}, {20'h0_0000, e});
	endtask
	// Bounded poll until masked bits match
	task automatic poll(input logic [11:0] a, input logic [11:0] m, input logic [11:0] e);
		int k;
		k = 0;
		do begin
			apb(1'b0, a, 12'h000);
			k++;
		end while ((rv[11:0] & m) !== e && k < 1000);
		if (k >= 1000) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic t_reset();
		rck(`UFS_A_LVL, 12'hFFF, 12'h012);
		rck(`UFS_A_FLAG, 12'hFFF, 12'h090);
		rck(`UFS_A_RIS, 12'hFFF, 12'h020);
		rck(`UFS_A_MASK, 12'hFFF, 12'h000);
		rck(12'h028, 12'hFFF, 12'h000);
		chk(re, 1);
		$display("t_reset done");
	endtask
	task automatic t_tx();
		wr(`UFS_A_DIV, 12'h001);
		wr(`UFS_A_LCR, 12'h060);
		wr(`UFS_A_DATA, 12'h0A5);
		rck(`UFS_A_FLAG, 12'h0A8, 12'h028);
		rck(`UFS_A_RIS, 12'h020, 12'h000);
		n0 = u_peer.rx_count;
		wr(`UFS_A_CTL, 12'h301);
		wr(`UFS_A_CTL, 12'h300);
		rck(`UFS_A_FLAG, 12'h008, 12'h008);
		poll(`UFS_A_FLAG, 12'h008, 12'h000);
		chk(u_peer.rx_count - n0, 1);
		chk(u_peer.rx_byte, 32'h0000_00A5);
		rck(`UFS_A_RIS, 12'h020, 12'h020);
		$display("t_tx done");
	endtask
	task automatic t_fifo();
		wr(`UFS_A_LCR, 12'h070);
		for (int i = 1; i <= 17; i++) wr(`UFS_A_DATA, 12'(i));
		rck(`UFS_A_FLAG, 12'h0A8, 12'h028);
		rck(`UFS_A_RIS, 12'h020, 12'h000);
		n0 = u_peer.rx_count;
		wr(`UFS_A_CTL, 12'h301);
		poll(`UFS_A_FLAG, 12'h008, 12'h000);
		chk(u_peer.rx_count - n0, 16);
		chk(u_peer.rx_byte, 32'h0000_0010);
		rck(`UFS_A_RIS, 12'h020, 12'h020);
		$display("t_fifo done");
	endtask
	task automatic t_rx();
		wr(`UFS_A_LVL, 12'h00A);
		wr(`UFS_A_MASK, 12'h010);
		for (int i = 0; i < 3; i++) u_peer.send(8'(8'h30 + i), 1'b1);
		rck(`UFS_A_RIS, 12'h010, 12'h000);
		chk(irq, 0);
		u_peer.send(8'h33, 1'b1);
		rck(`UFS_A_RIS, 12'h010, 12'h010);
		chk(irq, 1);
		rck(`UFS_A_DATA, 12'hFFF, 12'h030);
		rck(`UFS_A_RIS, 12'h010, 12'h000);
		chk(irq, 0);
		for (int i = 1; i < 4; i++) rck(`UFS_A_DATA, 12'hFFF, 12'(12'h030 + i));
		rck(`UFS_A_FLAG, 12'h010, 12'h010);
		$display("t_rx done");
	endtask
	task automatic t_err();
		u_peer.send(8'h3C, 1'b0);
		rck(`UFS_A_RIS, 12'h080, 12'h080);
		rck(`UFS_A_MIS, 12'h080, 12'h000);
		wr(`UFS_A_ICR, 12'h080);
		rck(`UFS_A_RIS, 12'h080, 12'h000);
		rck(`UFS_A_DATA, 12'hFFF, 12'h13C);
		u_peer.glitch(4);
		repeat (200) @(posedge pclk);
		rck(`UFS_A_FLAG, 12'h010, 12'h010);
		u_peer.glitch(12);
		repeat (200) @(posedge pclk);
		rck(`UFS_A_DATA, 12'hFFF, 12'h0FF);
		$display("t_err done");
	endtask
	task automatic t_loop();
		wr(`UFS_A_LCR, 12'h060);
		wr(`UFS_A_CTL, 12'h381);
		wr(`UFS_A_DATA, 12'h05A);
		poll(`UFS_A_FLAG, 12'h010, 12'h000);
		rck(`UFS_A_RIS, 12'h010, 12'h010);
		rck(`UFS_A_DATA, 12'hFFF, 12'h05A);
		rck(`UFS_A_RIS, 12'h010, 12'h000);
		$display("t_loop done");
	endtask
	task automatic t_ovr();
		wr(`UFS_A_DATA, 12'h011);
		poll(`UFS_A_FLAG, 12'h008, 12'h000);
		wr(`UFS_A_DATA, 12'h022);
		poll(`UFS_A_FLAG, 12'h008, 12'h000);
		rck(`UFS_A_RIS, 12'h400, 12'h400);
		rck(`UFS_A_RSR, 12'h00F, 12'h008);
		rck(`UFS_A_DATA, 12'hFFF, 12'h011);
		wr(`UFS_A_ICR, 12'h400);
		wr(`UFS_A_RSR, 12'h000);
		rck(`UFS_A_RSR, 12'h00F, 12'h000);
		rck(`UFS_A_RIS, 12'h400, 12'h000);
		wr(`UFS_A_DATA, 12'h033);
		poll(`UFS_A_FLAG, 12'h010, 12'h000);
		rck(`UFS_A_DATA, 12'hFFF, 12'h833);
		$display("t_ovr done");
	endtask
	task automatic t_rt();
		wr(`UFS_A_LCR, 12'h066);
		wr(`UFS_A_ICR, 12'h040);
		wr(`UFS_A_DATA, 12'h044);
		poll(`UFS_A_FLAG, 12'h010, 12'h000);
		rck(`UFS_A_RIS, 12'h040, 12'h000);
		repeat (600) @(posedge pclk);
		rck(`UFS_A_RIS, 12'h040, 12'h040);
		rck(`UFS_A_DATA, 12'hFFF, 12'h044);
		wr(`UFS_A_ICR, 12'h040);
		rck(`UFS_A_RIS, 12'h040, 12'h000);
		wr(`UFS_A_LCR, 12'h060);
		$display("t_rt done");
	endtask
	task automatic t_freeze();
		logic v;
		wr(`UFS_A_DATA, 12'h055);
		repeat (40) @(posedge pclk);
		pclk_en <= 1'b0;
		@(posedge pclk);
		v = serial_out;
		repeat (110) @(posedge pclk);
		chk(serial_out, v);
		pclk_en <= 1'b1;
		poll(`UFS_A_FLAG, 12'h010, 12'h000);
		rck(`UFS_A_DATA, 12'hFFF, 12'h055);
		$display("t_freeze done");
	endtask
	task automatic t_ir();
		wr(`UFS_A_ILPR, 12'h002);
		for (int m = 0; m < 2; m++) begin
			wr(`UFS_A_CTL, m ? 12'h307 : 12'h303);
			n0 = n_rise;
			wr(`UFS_A_DATA, 12'h00F);
			poll(`UFS_A_FLAG, 12'h008, 12'h000);
			chk(n_rise - n0, 5);
		end
		$display("t_ir done");
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_tx();
		t_fifo();
		t_rx();
		t_err();
		t_loop();
		t_ovr();
		t_rt();
		t_freeze();
		t_ir();
		report_and_stop();
	end
endmodule // tb_top
